// ### inc/static_memory_select_pkg.sv
// Overview of operation
// - Eight selects each decode one 256 Mbyte region with its own timing and width.
// - Two 32-bit read/write configuration registers are cleared to zero by reset.
// - The low register holds selects 0 to 3, select 0 in bits 7:0 rising a byte per select.
// - The high register holds selects 4 to 7, select 4 lowest and select 7 in bits 31:24.
// - Every byte is clock enable 7, sequential enable 6, sequential waits 5:4, random waits 3:2, width 1:0.
// - With the boot flag clear, width codes 00,01,10,11 mean 32-bit, 16-bit, 8-bit and card mode.
// - With the boot flag set, width codes 00,01,10,11 mean 8-bit, card mode, 32-bit and 16-bit.
// - The boot flag is caught from port E bit 0 at reset, high meaning 8-bit; the board holds the pin.
// - In card mode address bits 27:26 pick 8-bit attribute, 16-bit common, 8-bit I/O or 16-bit I/O.
// - Card areas other than 16-bit I/O split a word access into byte or halfword accesses.
// - 16-bit card I/O never splits a word and data bits 31:16 read as zero.
// - 16-bit card I/O drives external address bit 1 from address bit 25 and bit 25 as zero.
// - Random wait codes 00,01,10,11 insert 4, 3, 2 and 1 wait states.
// - Sequential wait codes 00,01,10,11 insert 3, 2, 1 and 0 wait states.
// - With sequential enable, quad-word aligned runs use page timing, broken after four words.
// - With the select clock enable set the expansion clock runs during access and ready may stretch it.
package static_memory_select_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0]  ADDR_CFG_LOW       = 4'h0;
	localparam logic [3:0]  ADDR_CFG_HIGH      = 4'h4;
	localparam logic [3:0]  ADDR_STATUS        = 4'h8;
	localparam logic [31:0] CFG_RESET          = 32'h0000_0000;
	localparam int          STAT_BOOT_BIT      = 0;
	localparam int          STAT_BUSY_BIT      = 1;
	// ****************************************
	// Per-select byte layout
	// ****************************************
	localparam int          FIELD_W            = 8;
	localparam int          CLK_EN_BIT         = 7;
	localparam int          SEQ_EN_BIT         = 6;
	localparam int          SEQ_WAIT_LSB       = 4;
	localparam int          RAND_WAIT_LSB      = 2;
	localparam int          WIDTH_LSB          = 0;
	localparam logic [1:0]  BOOT_WIDTH_XOR     = 2'h2;
	// ****************************************
	// Address decode
	// ****************************************
	localparam int          SEL_LSB            = 28;
	localparam int          CARD_A26           = 26;
	localparam int          CARD_A27           = 27;
	localparam int          IO_A1_SRC          = 25;
	localparam int          IO_ZERO_BIT        = 25;
	// ****************************************
	// Timing
	// ****************************************
	localparam logic [2:0]  RAND_WAIT_BASE     = 3'h4;
	localparam logic [2:0]  SEQ_WAIT_BASE      = 3'h3;
	localparam logic [3:0]  ACCESS_MIN_CYCLES  = 4'h3;
	localparam logic [2:0]  BURST_WORDS        = 3'h4;
	localparam logic [1:0]  BOOT_SETTLE        = 2'h2;

	typedef enum logic [1:0] {WIDTH_32, WIDTH_16, WIDTH_8, WIDTH_CARD} width_t;
endpackage

// ### src/select_field_decode.sv
`timescale 1ns/100ps
module select_field_decode (
	input  wire logic [7:0] field,
	input  wire logic       boot_width_flag,
	input  wire logic       a27,
	input  wire logic       a26,
	output logic      [1:0] piece_log,
	output logic            card_io16,
	output logic      [2:0] rand_waits,
	output logic      [2:0] seq_waits,
	output logic            sequential_access_enable,
	output logic            select_clock_output_enable
);
	static_memory_select_pkg::width_t wsel;
	logic [1:0]                       code;

	always_comb begin
		code = field[static_memory_select_pkg::WIDTH_LSB +: 2];
		// Boot flag rotates the table so a cleared byte means 8-bit
		if (boot_width_flag) begin
			code = code ^ static_memory_select_pkg::BOOT_WIDTH_XOR;
		end
		wsel = static_memory_select_pkg::width_t'(code);
		card_io16 = 1'b0;
		unique case (wsel)
			static_memory_select_pkg::WIDTH_32: piece_log = 2'h2;
			static_memory_select_pkg::WIDTH_16: piece_log = 2'h1;
			static_memory_select_pkg::WIDTH_8:  piece_log = 2'h0;
			static_memory_select_pkg::WIDTH_CARD: begin
				piece_log = {1'b0, a26};
				card_io16 = a26 & a27;
			end
		endcase
	end

	assign rand_waits = static_memory_select_pkg::RAND_WAIT_BASE
		- {1'b0, field[static_memory_select_pkg::RAND_WAIT_LSB +: 2]};
	assign seq_waits = static_memory_select_pkg::SEQ_WAIT_BASE
		- {1'b0, field[static_memory_select_pkg::SEQ_WAIT_LSB +: 2]};
	assign sequential_access_enable = field[static_memory_select_pkg::SEQ_EN_BIT];
	assign select_clock_output_enable = field[static_memory_select_pkg::CLK_EN_BIT];
endmodule

// ### src/static_memory_select_config.sv
`timescale 1ns/100ps
module static_memory_select_config (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	// ****************************************
	// Register port
	// ****************************************
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// ****************************************
	// Processor access port
	// ****************************************
	input  wire logic        cpu_req,
	input  wire logic [31:0] cpu_addr,
	input  wire logic        cpu_write,
	input  wire logic [1:0]  cpu_size,
	input  wire logic        cpu_seq,
	input  wire logic [31:0] cpu_wdata,
	output logic             cpu_ready,
	output logic             cpu_done,
	output logic      [31:0] cpu_rdata,
	// ****************************************
	// Expansion pins
	// ****************************************
	input  wire logic        port_e0_in,
	input  wire logic        expansion_ready_in,
	input  wire logic [31:0] ext_data_in,
	output logic      [31:0] ext_data_out,
	output logic             ext_data_oe,
	output logic      [27:0] ext_addr,
	output logic             ext_oe_n,
	output logic             ext_we_n,
	output logic             expansion_clock_out,
	output logic             select_0_n,
	output logic             select_1_n,
	output logic             select_2_n,
	output logic             select_3_n,
	output logic             select_4,
	output logic             select_5,
	output logic             select_6,
	output logic             select_7
);
	typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_TURN} state_t;

	state_t      state_r;
	logic [31:0] cfg_low_r;
	logic [31:0] cfg_high_r;
	logic        boot_width_flag;
	logic        boot_done_r;
	logic [1:0]  boot_cnt_r;
	logic        pe0_s1_r;
	logic        pe0_s2_r;
	logic        rdy_s1_r;
	logic        rdy_s2_r;
	logic [31:0] din_s1_r;
	logic [31:0] din_s2_r;
	logic [31:0] addr_r;
	logic        write_r;
	logic [1:0]  size_r;
	logic [31:0] wdata_r;
	logic [31:0] rdata_r;
	logic        seq_timing_r;
	logic [2:0]  burst_cnt_r;
	logic [3:0]  cnt_r;
	logic [1:0]  piece_r;
	logic [7:0]  sel_r;
	logic        exp_clk_r;
	logic        done_r;
	logic [31:0] addr_cur;
	logic [63:0] cfg_all;
	logic [7:0]  field;
	logic [2:0]  sel_idx;
	logic [1:0]  piece_log;
	logic        card_io16;
	logic [2:0]  rand_waits;
	logic [2:0]  seq_waits;
	logic        seq_en;
	logic        sel_clk_en;
	logic [1:0]  pieces_log;
	logic [1:0]  last_piece;
	logic [1:0]  off;
	logic        take;
	logic        use_seq;
	logic        piece_end;
	logic        word_end;
	logic [3:0]  load_cnt;
	logic [1:0]  next_off;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pe0_s1_r <= 1'b0;
			pe0_s2_r <= 1'b0;
			rdy_s1_r <= 1'b0;
			rdy_s2_r <= 1'b0;
			din_s1_r <= 32'h0000_0000;
			din_s2_r <= 32'h0000_0000;
		end else if (clk_en) begin
			pe0_s1_r <= port_e0_in;
			pe0_s2_r <= pe0_s1_r;
			rdy_s1_r <= expansion_ready_in;
			rdy_s2_r <= rdy_s1_r;
			din_s1_r <= ext_data_in;
			din_s2_r <= din_s1_r;
		end
	end

	// ****************************************
	// Boot width strap
	// ****************************************
	// Caught once the synchroniser has filled after reset release
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			boot_cnt_r <= 2'h0;
			boot_done_r <= 1'b0;
			boot_width_flag <= 1'b0;
		end else if (clk_en && !boot_done_r) begin
			if (boot_cnt_r == static_memory_select_pkg::BOOT_SETTLE) begin
				boot_width_flag <= pe0_s2_r;
				boot_done_r <= 1'b1;
			end else begin
				boot_cnt_r <= boot_cnt_r + 2'h1;
			end
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_low_r <= static_memory_select_pkg::CFG_RESET;
			cfg_high_r <= static_memory_select_pkg::CFG_RESET;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == static_memory_select_pkg::ADDR_CFG_LOW) begin
				cfg_low_r <= reg_wdata;
			end
			if (reg_addr == static_memory_select_pkg::ADDR_CFG_HIGH) begin
				cfg_high_r <= reg_wdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				unique case (reg_addr)
					static_memory_select_pkg::ADDR_CFG_LOW:  reg_rdata <= cfg_low_r;
					static_memory_select_pkg::ADDR_CFG_HIGH: reg_rdata <= cfg_high_r;
					static_memory_select_pkg::ADDR_STATUS: begin
						reg_rdata[static_memory_select_pkg::STAT_BOOT_BIT] <= boot_width_flag;
						reg_rdata[static_memory_select_pkg::STAT_BUSY_BIT] <= (state_r != ST_IDLE);
					end
					default: reg_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Select decode
	// ****************************************
	assign take = cpu_ready & cpu_req;
	assign addr_cur = (state_r == ST_IDLE) ? cpu_addr : addr_r;
	assign sel_idx = addr_cur[static_memory_select_pkg::SEL_LSB +: 3];
	assign cfg_all = {cfg_high_r, cfg_low_r};
	assign field = cfg_all[{sel_idx, 3'h0} +: static_memory_select_pkg::FIELD_W];

	select_field_decode u_decode (
		.field                      (field),
		.boot_width_flag            (boot_width_flag),
		.a27                        (addr_cur[static_memory_select_pkg::CARD_A27]),
		.a26                        (addr_cur[static_memory_select_pkg::CARD_A26]),
		.piece_log                  (piece_log),
		.card_io16                  (card_io16),
		.rand_waits                 (rand_waits),
		.seq_waits                  (seq_waits),
		.sequential_access_enable   (seq_en),
		.select_clock_output_enable (sel_clk_en)
	);

	// ****************************************
	// Splitting into pieces
	// ****************************************
	always_comb begin
		pieces_log = 2'h0;
		if (!card_io16 && size_r > piece_log) begin
			pieces_log = size_r - piece_log;
		end
		last_piece = 2'h3 >> (2'h2 - pieces_log);
		if (pieces_log == 2'h0) begin
			off = addr_r[1:0];
		end else begin
			off = 2'((piece_r << piece_log) | (addr_r[1:0] & ~(2'h3 >> (2'h2 - size_r))));
		end
		next_off = off;
	end

	// A page burst covers four words from a quad-word boundary only
	assign use_seq = seq_en & cpu_seq & (burst_cnt_r != 3'h0)
		& (burst_cnt_r < static_memory_select_pkg::BURST_WORDS);
	assign load_cnt = static_memory_select_pkg::ACCESS_MIN_CYCLES - 4'h1
		+ {1'b0, (seq_timing_r ? seq_waits : rand_waits)};
	// Ready only counts when the select runs the clock that paces it
	assign piece_end = (state_r == ST_ACCESS) && (cnt_r == 4'h0)
		&& (!sel_clk_en || rdy_s2_r);
	assign word_end = piece_end && (piece_r == last_piece);

	// ****************************************
	// Access sequencer
	// ****************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_IDLE;
			addr_r <= 32'h0000_0000;
			write_r <= 1'b0;
			size_r <= 2'h0;
			wdata_r <= 32'h0000_0000;
			seq_timing_r <= 1'b0;
			burst_cnt_r <= 3'h0;
			cnt_r <= 4'h0;
			piece_r <= 2'h0;
		end else if (clk_en) begin
			unique case (state_r)
				ST_IDLE: begin
					if (take) begin
						addr_r <= cpu_addr;
						write_r <= cpu_write;
						size_r <= cpu_size;
						wdata_r <= cpu_wdata;
						piece_r <= 2'h0;
						seq_timing_r <= use_seq;
						if (use_seq) begin
							burst_cnt_r <= burst_cnt_r + 3'h1;
						end else if (seq_en && cpu_addr[3:2] == 2'h0) begin
							burst_cnt_r <= 3'h1;
						end else begin
							burst_cnt_r <= 3'h0;
						end
						state_r <= ST_TURN;
					end
				end
				ST_TURN: begin
					cnt_r <= load_cnt;
					state_r <= ST_ACCESS;
				end
				ST_ACCESS: begin
					if (cnt_r != 4'h0) begin
						cnt_r <= cnt_r - 4'h1;
					end else if (word_end) begin
						state_r <= ST_IDLE;
					end else if (piece_end) begin
						piece_r <= piece_r + 2'h1;
						state_r <= ST_TURN;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Read data assembly
	// ****************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (clk_en) begin
			if (take) begin
				rdata_r <= 32'h0000_0000;
			end else if (piece_end && !write_r) begin
				if (card_io16) begin
					rdata_r <= {16'h0000, din_s2_r[15:0]};
				end else begin
					unique case (piece_log)
						2'h0:    rdata_r[{off, 3'h0} +: 8] <= din_s2_r[7:0];
						2'h1:    rdata_r[{off[1], 4'h0} +: 16] <= din_s2_r[15:0];
						default: rdata_r <= din_s2_r;
					endcase
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			done_r <= 1'b0;
		end else if (clk_en) begin
			done_r <= word_end;
		end
	end

	assign cpu_ready = (state_r == ST_IDLE) && boot_done_r;
	assign cpu_done = done_r;
	assign cpu_rdata = rdata_r;

	// ****************************************
	// Expansion pin drive
	// ****************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ext_addr <= 28'h000_0000;
			ext_data_out <= 32'h0000_0000;
			ext_data_oe <= 1'b0;
			ext_oe_n <= 1'b1;
			ext_we_n <= 1'b1;
			sel_r <= 8'h00;
		end else if (clk_en) begin
			if (state_r == ST_TURN) begin
				ext_addr <= {addr_r[27:2], next_off};
				if (card_io16) begin
					ext_addr[1] <= addr_r[static_memory_select_pkg::IO_A1_SRC];
					ext_addr[static_memory_select_pkg::IO_ZERO_BIT] <= 1'b0;
				end
				ext_data_out <= wdata_r >> {next_off, 3'h0};
				ext_data_oe <= write_r;
				ext_oe_n <= write_r;
				ext_we_n <= !write_r;
				sel_r <= 8'h01 << sel_idx;
			end else if (piece_end) begin
				ext_data_oe <= 1'b0;
				ext_oe_n <= 1'b1;
				ext_we_n <= 1'b1;
				if (word_end) begin
					sel_r <= 8'h00;
				end
			end
		end
	end

	// Half-rate reference; back-to-back pieces keep it toggling
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			exp_clk_r <= 1'b0;
		end else if (clk_en) begin
			if (state_r != ST_IDLE && sel_clk_en) begin
				exp_clk_r <= !exp_clk_r;
			end else begin
				exp_clk_r <= 1'b0;
			end
		end
	end

	assign expansion_clock_out = exp_clk_r;
	assign select_0_n = !sel_r[0];
	assign select_1_n = !sel_r[1];
	assign select_2_n = !sel_r[2];
	assign select_3_n = !sel_r[3];
	assign select_4 = sel_r[4];
	assign select_5 = sel_r[5];
	assign select_6 = sel_r[6];
	assign select_7 = sel_r[7];
endmodule

// ### testbench/ext_memory_model.sv
`timescale 1ns/100ps
module ext_memory_model (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        slow,
	input  wire logic [27:0] ext_addr,
	input  wire logic        ext_oe_n,
	input  wire logic        ext_we_n,
	output logic      [31:0] ext_data_in,
	output logic             expansion_ready_in
);
	logic [31:0] last_r;
	logic [2:0]  stall_r;

	// Released bus shows the inverse of the last value, so a stale sample cannot pass
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			last_r <= 32'h0;
		end else if (!ext_oe_n) begin
			last_r <= ext_data_in;
		end
	end
	assign ext_data_in = ext_oe_n ? ~last_r : {ext_addr[15:0], ~ext_addr[15:0]};

	// A slow part holds ready low for the first cycles of each strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stall_r <= 3'h0;
		end else if (ext_oe_n && ext_we_n) begin
			stall_r <= 3'h0;
		end else if (stall_r != 3'h7) begin
			stall_r <= stall_r + 3'h1;
		end
	end
	assign expansion_ready_in = !slow || stall_r > 3'h3;
endmodule

// ### testbench/static_memory_select_asserts.sv
`timescale 1ns/100ps
module static_memory_select_asserts (
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        cpu_req,
	input wire logic        cpu_ready,
	input wire logic        cpu_done,
	input wire logic        ext_oe_n,
	input wire logic        ext_we_n,
	input wire logic        ext_data_oe,
	input wire logic        expansion_clock_out,
	input wire logic        select_0_n,
	input wire logic        select_1_n,
	input wire logic        select_2_n,
	input wire logic        select_3_n,
	input wire logic        select_4,
	input wire logic        select_5,
	input wire logic        select_6,
	input wire logic        select_7
);
	logic [7:0] act;

	// Selects folded to active high
	assign act = {select_7, select_6, select_5, select_4, ~select_3_n, ~select_2_n, ~select_1_n, ~select_0_n};
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// ********************
	// Checks
	// ********************
	read_slot_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	take_busy_a: assert property (cpu_req && cpu_ready |=> !cpu_ready)
		else $error("ready stayed high after a take");
	min_access_a: assert property (cpu_req && cpu_ready |=> (!cpu_done)[*4] ##[1:300] cpu_done)
		else $error("access shorter than minimum or never done");
	done_pulse_a: assert property (cpu_done |=> !cpu_done)
		else $error("done longer than one cycle");
	select_onehot_a: assert property ($onehot0(act))
		else $error("two selects active");
	select_hold_a: assert property ($fell(cpu_ready) |=> (act != 8'h0)[*3])
		else $error("select dropped during access");
	idle_quiet_a: assert property (cpu_ready |-> act == 8'h0 && ext_oe_n && ext_we_n)
		else $error("bus active while idle");
	clk_idle_a: assert property (cpu_ready[*2] |-> !expansion_clock_out)
		else $error("expansion clock runs while idle");
	bus_dir_a: assert property (ext_data_oe |-> ext_oe_n)
		else $error("data driven during a read");
endmodule

bind static_memory_select_config static_memory_select_asserts chk_u (
	.mclk, .arst_n, .reg_rd, .reg_rdata, .cpu_req, .cpu_ready, .cpu_done, .ext_oe_n, .ext_we_n,
	.ext_data_oe, .expansion_clock_out, .select_0_n, .select_1_n, .select_2_n, .select_3_n,
	.select_4, .select_5, .select_6, .select_7
);

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
	typedef struct packed {
		logic        boot;
		logic [2:0]  sel;
		logic [7:0]  fld;
		logic [27:0] addr;
		logic        seq;
		logic        slow;
		logic        wr;
		logic [7:0]  cyc;
	} row_t;
	logic        mclk, arst_n, clk_en, reg_wr, reg_rd, cpu_req, cpu_write, cpu_seq, port_e0_in, slow;
	logic        cpu_ready, cpu_done, expansion_ready_in, ext_data_oe, ext_oe_n, ext_we_n, expansion_clock_out;
	logic        select_0_n, select_1_n, select_2_n, select_3_n, select_4, select_5, select_6, select_7;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, cpu_addr, cpu_wdata, cpu_rdata, ext_data_in, ext_data_out;
	logic [27:0] ext_addr;
	logic [7:0]  sel_act;
	int          mismatches, check_count;
	// Cycle count 0 means a stalled access, only known to be longer than the minimum
	row_t        rows [18] = '{
		'{1'h0, 3'h0, 8'h00, 28'h0000100, 1'h0, 1'h0, 1'h0, 8'h09}, '{1'h0, 3'h1, 8'h05, 28'h0000104, 1'h0, 1'h0, 1'h0, 8'h0f},
		'{1'h0, 3'h2, 8'h0a, 28'h0000108, 1'h0, 1'h0, 1'h0, 8'h19}, '{1'h0, 3'h4, 8'h0f, 28'h0000000, 1'h0, 1'h0, 1'h0, 8'h15},
		'{1'h0, 3'h5, 8'h0f, 28'h4000010, 1'h0, 1'h0, 1'h0, 8'h0b}, '{1'h0, 3'h6, 8'h0f, 28'h8000020, 1'h0, 1'h0, 1'h0, 8'h15},
		'{1'h0, 3'h7, 8'h0f, 28'he000040, 1'h0, 1'h0, 1'h0, 8'h06}, '{1'h0, 3'h3, 8'h8c, 28'h0000030, 1'h0, 1'h1, 1'h0, 8'h00},
		'{1'h0, 3'h3, 8'h0c, 28'h0000034, 1'h0, 1'h1, 1'h1, 8'h06}, '{1'h0, 3'h1, 8'h4c, 28'h0000200, 1'h0, 1'h0, 1'h0, 8'h06},
		'{1'h0, 3'h1, 8'h4c, 28'h0000204, 1'h1, 1'h0, 1'h0, 8'h08}, '{1'h0, 3'h1, 8'h4c, 28'h0000208, 1'h1, 1'h0, 1'h0, 8'h08},
		'{1'h0, 3'h1, 8'h4c, 28'h000020c, 1'h1, 1'h0, 1'h0, 8'h08}, '{1'h0, 3'h1, 8'h4c, 28'h0000210, 1'h1, 1'h0, 1'h0, 8'h06},
		'{1'h1, 3'h0, 8'h00, 28'hc000000, 1'h0, 1'h0, 1'h0, 8'h21}, '{1'h1, 3'h0, 8'h01, 28'hc000000, 1'h0, 1'h0, 1'h0, 8'h09},
		'{1'h1, 3'h0, 8'h02, 28'hc000000, 1'h0, 1'h0, 1'h0, 8'h09}, '{1'h1, 3'h0, 8'h03, 28'hc000000, 1'h0, 1'h0, 1'h0, 8'h11}};

	assign sel_act = {select_7, select_6, select_5, select_4, ~select_3_n, ~select_2_n, ~select_1_n, ~select_0_n};
	initial mclk = 1'h0;
	always #20 mclk = ~mclk;

	static_memory_select_config dut_u (
		.mclk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.cpu_req, .cpu_addr, .cpu_write, .cpu_size(2'h2), .cpu_seq, .cpu_wdata, .cpu_ready, .cpu_done,
		.cpu_rdata, .port_e0_in, .expansion_ready_in, .ext_data_in, .ext_data_out, .ext_data_oe,
		.ext_addr, .ext_oe_n, .ext_we_n, .expansion_clock_out, .select_0_n, .select_1_n, .select_2_n,
		.select_3_n, .select_4, .select_5, .select_6, .select_7
	);
	ext_memory_model mem_u (.mclk, .arst_n, .slow, .ext_addr, .ext_oe_n, .ext_we_n, .ext_data_in, .expansion_ready_in);

	// ********************
	// Tasks
	// ********************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(negedge mclk);
		v = reg_rdata;
	endtask

	// Counts cycles from the take edge to the done cycle
	task automatic go(input row_t rw, input logic [27:0] ea, output int n, output logic cs);
		int k;
		@(posedge mclk);
		cpu_req   <= 1'h1;
		cpu_addr  <= {1'h0, rw.sel, rw.addr};
		cpu_seq   <= rw.seq;
		cpu_write <= rw.wr;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (cpu_ready !== 1'h1 && k < 50);
		@(posedge mclk);
		cpu_req <= 1'h0;
		n  = 0;
		cs = 1'h0;
		do begin
			@(negedge mclk);
			n++;
			if (expansion_clock_out === 1'h1) cs = 1'h1;
			if (n == 2) begin
				check({24'h0, sel_act}, 32'h1 << rw.sel);
				check({4'h0, ext_addr}, {4'h0, ea});
				check({29'h0, ext_oe_n, ext_we_n, ext_data_oe}, rw.wr ? 32'h5 : 32'h2);
				if (rw.wr) check(ext_data_out, cpu_wdata);
			end
		end while (cpu_done !== 1'h1 && n < 200);
		// A request never taken or an access never done is a failure by itself
		if (k >= 50 || n >= 200) mismatches++;
	endtask

	// ********************
	// Sequence
	// ********************
	initial begin
		logic [31:0] d, rd, exp_rd;
		logic [1:0]  wc, lg;
		logic [27:0] ea;
		logic [10:0] prev;
		logic        io16, cs;
		int          n;
		{arst_n, reg_wr, reg_rd, cpu_req, cpu_write, cpu_seq, port_e0_in, slow} = 8'h0;
		clk_en      = 1'h1;
		reg_addr    = 4'h0;
		reg_wdata   = 32'h0;
		cpu_addr    = 32'h0;
		cpu_wdata   = 32'h1234_abcd;
		mismatches  = 0;
		check_count = 0;
		prev        = 11'h7ff;
		repeat (8) @(posedge mclk);
		arst_n <= 1'h1;
		reg_write(4'h8, 32'hffff_ffff);
		reg_write(4'hc, 32'hffff_ffff);
		for (int i = 0; i < 4; i++) begin
			reg_read(4'(i * 4), d);
			check(d, 32'h0);
		end
		for (int r = 0; r < 18; r++) begin
			if (rows[r].boot !== port_e0_in) begin
				@(posedge mclk);
				port_e0_in <= rows[r].boot;
				arst_n     <= 1'h0;
				repeat (8) @(posedge mclk);
				arst_n <= 1'h1;
				reg_read(4'h0, d);
				check(d, 32'h0);
				reg_read(4'h8, d);
				check(d, {31'h0, rows[r].boot});
				prev = 11'h7ff;
			end
			if ({rows[r].sel, rows[r].fld} != prev) begin
				d = {24'h0, rows[r].fld} << (8 * rows[r].sel[1:0]);
				reg_write(rows[r].sel[2] ? 4'h4 : 4'h0, d);
				reg_read(rows[r].sel[2] ? 4'h4 : 4'h0, rd);
				check(rd, d);
				prev = {rows[r].sel, rows[r].fld};
			end
			slow = rows[r].slow;
			io16 = rows[r].fld[1:0] == (rows[r].boot ? 2'h1 : 2'h3) && rows[r].addr[27:26] == 2'h3;
			ea   = rows[r].addr;
			if (io16) begin
				ea[1]  = ea[25];
				ea[25] = 1'h0;
			end
			go(rows[r], ea, n, cs);
			check({31'h0, cs}, {31'h0, rows[r].fld[7]});
			if (rows[r].cyc == 8'h0) check({31'h0, n > 6}, 32'h1);
			else check(32'(n), {24'h0, rows[r].cyc});
			if (io16 && !rows[r].wr) check({16'h0, cpu_rdata[31:16]}, 32'h0);
			// Lane order follows the memory model, which answers each piece with its own address
			wc = rows[r].fld[1:0] ^ {rows[r].boot, 1'h0};
			lg = (wc == 2'h3) ? {1'h0, rows[r].addr[26]} : 2'h2 - wc;
			if (io16) exp_rd = {16'h0, ~ea[15:0]};
			else if (lg == 2'h2) exp_rd = {ea[15:0], ~ea[15:0]};
			else if (lg == 2'h1) exp_rd = {~ea[15:2], 2'h1, ~ea[15:2], 2'h3};
			else exp_rd = {~ea[7:2], 2'h0, ~ea[7:2], 2'h1, ~ea[7:2], 2'h2, ~ea[7:2], 2'h3};
			if (!rows[r].wr) check(cpu_rdata, exp_rd);
		end
		// Clock enable low must freeze the registers against a write
		@(posedge mclk);
		clk_en <= 1'h0;
		reg_write(4'h0, 32'h5a5a_5a5a);
		@(posedge mclk);
		clk_en <= 1'h1;
		reg_read(4'h0, d);
		check(d, 32'h0000_0003);
		wrap_up();
	end

	// Whole run needs a few hundred cycles
	initial begin
		#(40 * 20000);
		mismatches++;
		wrap_up();
	end
endmodule
